// file: core/pci_cfg_pkg.sv
/*
 * Constants for the configuration-space header block: register byte
 * offsets, field positions, reset values, writable masks and the state
 * type of the recall sequencer.
 * Assumes a 256-byte configuration space addressed by byte with
 * 32-bit aligned words.
 */
package pci_cfg_pkg;

   // -------------------------------------------------------------
   // register offsets
   // -------------------------------------------------------------
   localparam logic [7:0] OFF_LOADED_IDENT = 8'h00;
   localparam logic [7:0] OFF_COMMAND_STATUS = 8'h04;
   localparam logic [7:0] OFF_CLASS_REVISION = 8'h08;
   localparam logic [7:0] OFF_LATENCY_CACHELINE = 8'h0C;
   localparam logic [7:0] OFF_IO_BASE = 8'h10;
   localparam logic [7:0] OFF_MEMORY_BASE = 8'h14;
   localparam logic [7:0] OFF_CARD_INFO_POINTER = 8'h28;
   localparam logic [7:0] OFF_SUBSYSTEM_IDENT = 8'h2C;
   localparam logic [7:0] OFF_BOOT_ROM_BASE = 8'h30;
   localparam logic [7:0] OFF_CAPABILITY_POINTER = 8'h34;
   localparam logic [7:0] OFF_INTERRUPT_CONFIG = 8'h3C;
   localparam logic [7:0] OFF_DRIVER_SCRATCH = 8'h40;
   localparam logic [7:0] OFF_CHIP_SIGNATURE = 8'h80;
   localparam logic [7:0] OFF_POWER_CAPABILITY = 8'hC0;
   localparam logic [7:0] OFF_POWER_CONTROL_STATUS = 8'hC4;

   // -------------------------------------------------------------
   // command/status fields
   // -------------------------------------------------------------
   localparam int BIT_IO_ENABLE = 0;
   localparam int BIT_MEM_ENABLE = 1;
   localparam int BIT_MASTER_ENABLE = 2;
   localparam int BIT_PARITY_RESPONSE = 6;
   localparam int BIT_SYSTEM_ERROR_EN = 8;
   localparam int BIT_NEW_CAPS = 20;
   localparam int BIT_FAST_B2B = 23;
   localparam int BIT_DATA_PARITY_REP = 24;
   localparam int BIT_DEVSEL_LO = 25;
   localparam int BIT_TARGET_ABORT = 28;
   localparam int BIT_MASTER_ABORT = 29;
   localparam int BIT_SYSTEM_ERROR = 30;
   localparam int BIT_PARITY_ERROR = 31;
   localparam logic [1:0] DEVSEL_MEDIUM = 2'h1;
   localparam logic [31:0] COMMAND_STATUS_RESET = 32'h0290_0000;

   // -------------------------------------------------------------
   // writable masks and fixed values
   // -------------------------------------------------------------
   localparam logic [31:0] MASK_LATENCY = 32'h0000_FFFF;
   localparam logic [31:0] MASK_IO_BASE = 32'hFFFF_FF00;
   localparam logic [31:0] MASK_MEMORY_BASE = 32'hFFFF_FC00;
   localparam logic [31:0] MASK_BOOT_ROM = 32'hFFFF_FC01;
   localparam logic [31:0] MASK_INT_LINE = 32'h0000_00FF;
   localparam logic [31:0] MASK_SCRATCH = 32'h0000_FF00;
   localparam logic [31:0] MASK_POWER_STATE = 32'h0000_0003;
   localparam logic [31:0] IO_SPACE_FLAG = 32'h0000_0001;
   localparam logic [7:0] CAPABILITY_IDENT_POWER = 8'h01;
   localparam logic [7:0] CAP_NEXT_NONE = 8'h00;

   typedef enum logic [1:0] {
      RECALL_START,
      RECALL_WAIT,
      RECALL_DONE
   } recall_state_t;

endpackage

// file: core/pci_config_header_regs.sv
/*
 * Configuration-space header register bank: identification, command and
 * status with error flags, base addresses, interrupt fields, scratch byte,
 * signature and power-management capability words.
 * Assumes the host-bridge side decodes configuration cycles into one-cycle
 * read/write strobes on ref_clk, and that the bus engine and EEPROM reader
 * run on the same clock and present one-cycle event pulses.
 */
`timescale 1ns/1ps
module pci_config_header_regs #(
   parameter logic [31:0] SIGNATURE_VALUE = 32'h1234_5678, // arbitrary
   parameter logic [31:0] CLASS_REVISION = 32'h0200_0011,
   parameter logic [15:0] POWER_CAPS = 16'h0000,
   parameter logic [7:0] INT_PIN = 8'h01
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // configuration access
   input wire logic cfgRead,
   input wire logic cfgWrite,
   input wire logic [7:0] cfgAddr,
   input wire logic [3:0] cfgByteEn,
   input wire logic [31:0] cfgWrData,
   output logic [31:0] cfgRdData,
   output logic cfgRdValid,
   // EEPROM recall
   output logic eeLoadRequest,
   input wire logic eeLoadDone,
   input wire logic [15:0] eeDeviceIdent,
   input wire logic [15:0] eeVendorIdent,
   input wire logic [31:0] eeCardInfo,
   input wire logic [31:0] eeSubsystemIdent,
   input wire logic [7:0] eeMaxLat,
   input wire logic [7:0] eeMinGnt,
   // bus engine events
   input wire logic dataParityErr,
   input wire logic addrParityErr,
   input wire logic masterAbort,
   input wire logic targetAbort,
   input wire logic busMasterActive,
   input wire logic perrDriven,
   input wire logic perrObserved,
   // error signalling
   output logic serrAssert,
   output logic perrAssert,
   output logic parityErrReport,
   // decoded controls
   output logic ioSpaceEnable,
   output logic memSpaceEnable,
   output logic busMasterEnable,
   output logic [7:0] latencyTimer,
   output logic [7:0] cacheLineSize,
   output logic [1:0] powerState
);

   generate
      if (INT_PIN > 8'h04) begin : g_bad_pin
         $error("interrupt pin must be 0 to 4");
      end
   endgenerate

   function automatic logic [31:0] mergeWord(input logic [31:0] oldV,
         input logic [31:0] newV, input logic [3:0] be,
         input logic [31:0] mask);
      logic [31:0] m;
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & mask;
      return (oldV & ~m) | (newV & m);
   endfunction

   function automatic logic setClear(input logic cur, input logic set,
         input logic clr);
      return set | (cur & ~clr);
   endfunction

   logic [15:0] loadedDeviceIdent_r;
   logic [15:0] loadedVendorIdent_r;
   logic [31:0] cardInfoPointer_r;
   logic [31:0] subsystemIdent_r;
   logic [7:0] maxLat_r;
   logic [7:0] minGnt_r;
   pci_cfg_pkg::recall_state_t recall_r;
   logic [31:0] latency_r;
   logic [31:0] ioBase_r;
   logic [31:0] memBase_r;
   logic [31:0] bootRom_r;
   logic [31:0] intLine_r;
   logic [31:0] scratch_r;
   logic [31:0] powerCtl_r;
   logic [31:0] command_r;
   logic parityErrorFlag_r;
   logic systemErrorFlag_r;
   logic masterAbortFlag_r;
   logic targetAbortFlag_r;
   logic dataParityFlag_r;
   logic [31:0] commandStatus;
   logic [31:0] readWord;
   logic wrCmd;
   logic clrByte3;

   // -------------------------------------------------------------
   // EEPROM recall sequencer
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         recall_r <= pci_cfg_pkg::RECALL_START;
         eeLoadRequest <= 1'b0;
      end else begin
         case (recall_r)
            pci_cfg_pkg::RECALL_START: begin
               recall_r <= pci_cfg_pkg::RECALL_WAIT;
               eeLoadRequest <= 1'b1;
            end
            pci_cfg_pkg::RECALL_WAIT: begin
               if (eeLoadDone) begin
                  recall_r <= pci_cfg_pkg::RECALL_DONE;
                  eeLoadRequest <= 1'b0;
               end
            end
            pci_cfg_pkg::RECALL_DONE: begin
               eeLoadRequest <= 1'b0;
            end
            default: begin
               recall_r <= pci_cfg_pkg::RECALL_START;
               eeLoadRequest <= 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         loadedDeviceIdent_r <= 16'h0000;
         loadedVendorIdent_r <= 16'h0000;
         cardInfoPointer_r <= 32'h0000_0000;
         subsystemIdent_r <= 32'h0000_0000;
         maxLat_r <= 8'h00;
         minGnt_r <= 8'h00;
      end else if (recall_r == pci_cfg_pkg::RECALL_WAIT && eeLoadDone) begin
         loadedDeviceIdent_r <= eeDeviceIdent;
         loadedVendorIdent_r <= eeVendorIdent;
         cardInfoPointer_r <= eeCardInfo;
         subsystemIdent_r <= eeSubsystemIdent;
         maxLat_r <= eeMaxLat;
         minGnt_r <= eeMinGnt;
      end
   end

   // -------------------------------------------------------------
   // software-writable registers
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         latency_r <= 32'h0000_0000;
         ioBase_r <= 32'h0000_0000;
         memBase_r <= 32'h0000_0000;
         bootRom_r <= 32'h0000_0000;
         intLine_r <= 32'h0000_0000;
         scratch_r <= 32'h0000_0000;
         powerCtl_r <= 32'h0000_0000;
      end else if (cfgWrite) begin
         // read-only and reserved offsets fall through untouched
         case (cfgAddr & 8'hFC)
            pci_cfg_pkg::OFF_LATENCY_CACHELINE:
               latency_r <= mergeWord(latency_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_LATENCY);
            pci_cfg_pkg::OFF_IO_BASE:
               ioBase_r <= mergeWord(ioBase_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_IO_BASE);
            pci_cfg_pkg::OFF_MEMORY_BASE:
               memBase_r <= mergeWord(memBase_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_MEMORY_BASE);
            pci_cfg_pkg::OFF_BOOT_ROM_BASE:
               bootRom_r <= mergeWord(bootRom_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_BOOT_ROM);
            pci_cfg_pkg::OFF_INTERRUPT_CONFIG:
               intLine_r <= mergeWord(intLine_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_INT_LINE);
            pci_cfg_pkg::OFF_DRIVER_SCRATCH:
               scratch_r <= mergeWord(scratch_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_SCRATCH);
            pci_cfg_pkg::OFF_POWER_CONTROL_STATUS:
               powerCtl_r <= mergeWord(powerCtl_r, cfgWrData, cfgByteEn,
                  pci_cfg_pkg::MASK_POWER_STATE);
            default: begin
            end
         endcase
      end
   end

   // -------------------------------------------------------------
   // command half
   // -------------------------------------------------------------
   assign wrCmd = cfgWrite &&
      (cfgAddr & 8'hFC) == pci_cfg_pkg::OFF_COMMAND_STATUS;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         command_r <= pci_cfg_pkg::COMMAND_STATUS_RESET &
            32'h0000_FFFF;
      end else if (wrCmd) begin
         command_r <= mergeWord(command_r, cfgWrData, cfgByteEn,
            (32'h1 << pci_cfg_pkg::BIT_IO_ENABLE) |
            (32'h1 << pci_cfg_pkg::BIT_MEM_ENABLE) |
            (32'h1 << pci_cfg_pkg::BIT_MASTER_ENABLE) |
            (32'h1 << pci_cfg_pkg::BIT_PARITY_RESPONSE) |
            (32'h1 << pci_cfg_pkg::BIT_SYSTEM_ERROR_EN));
      end
   end

   // -------------------------------------------------------------
   // error signalling
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         serrAssert <= 1'b0;
         perrAssert <= 1'b0;
         parityErrReport <= 1'b0;
      end else begin
         serrAssert <= addrParityErr &&
            command_r[pci_cfg_pkg::BIT_SYSTEM_ERROR_EN];
         perrAssert <= dataParityErr &&
            command_r[pci_cfg_pkg::BIT_PARITY_RESPONSE];
         parityErrReport <= (dataParityErr || addrParityErr) &&
            command_r[pci_cfg_pkg::BIT_PARITY_RESPONSE];
      end
   end

   // -------------------------------------------------------------
   // status flags: write one clears, a new event wins
   // -------------------------------------------------------------
   assign clrByte3 = wrCmd && cfgByteEn[3];

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         parityErrorFlag_r <= 1'b0;
         systemErrorFlag_r <= 1'b0;
         masterAbortFlag_r <= 1'b0;
         targetAbortFlag_r <= 1'b0;
         dataParityFlag_r <= 1'b0;
      end else begin
         parityErrorFlag_r <= setClear(parityErrorFlag_r,
            dataParityErr || addrParityErr,
            clrByte3 && cfgWrData[pci_cfg_pkg::BIT_PARITY_ERROR]);
         systemErrorFlag_r <= setClear(systemErrorFlag_r, serrAssert,
            clrByte3 && cfgWrData[pci_cfg_pkg::BIT_SYSTEM_ERROR]);
         masterAbortFlag_r <= setClear(masterAbortFlag_r, masterAbort,
            clrByte3 && cfgWrData[pci_cfg_pkg::BIT_MASTER_ABORT]);
         targetAbortFlag_r <= setClear(targetAbortFlag_r, targetAbort,
            clrByte3 && cfgWrData[pci_cfg_pkg::BIT_TARGET_ABORT]);
         dataParityFlag_r <= setClear(dataParityFlag_r,
            busMasterActive && (perrDriven || perrObserved) &&
            command_r[pci_cfg_pkg::BIT_PARITY_RESPONSE],
            clrByte3 && cfgWrData[pci_cfg_pkg::BIT_DATA_PARITY_REP]);
      end
   end

   always_comb begin
      commandStatus = command_r & 32'h0000_FFFF;
      commandStatus[pci_cfg_pkg::BIT_PARITY_ERROR] = parityErrorFlag_r;
      commandStatus[pci_cfg_pkg::BIT_SYSTEM_ERROR] = systemErrorFlag_r;
      commandStatus[pci_cfg_pkg::BIT_MASTER_ABORT] = masterAbortFlag_r;
      commandStatus[pci_cfg_pkg::BIT_TARGET_ABORT] = targetAbortFlag_r;
      commandStatus[pci_cfg_pkg::BIT_DATA_PARITY_REP] = dataParityFlag_r;
      commandStatus[pci_cfg_pkg::BIT_DEVSEL_LO +: 2] =
         pci_cfg_pkg::DEVSEL_MEDIUM;
      commandStatus[pci_cfg_pkg::BIT_FAST_B2B] = 1'b1;
      commandStatus[pci_cfg_pkg::BIT_NEW_CAPS] = 1'b1;
   end

   // -------------------------------------------------------------
   // read path
   // -------------------------------------------------------------
   always_comb begin
      case (cfgAddr & 8'hFC)
         pci_cfg_pkg::OFF_LOADED_IDENT:
            readWord = {loadedDeviceIdent_r, loadedVendorIdent_r};
         pci_cfg_pkg::OFF_COMMAND_STATUS:
            readWord = commandStatus;
         pci_cfg_pkg::OFF_CLASS_REVISION:
            readWord = CLASS_REVISION;
         pci_cfg_pkg::OFF_LATENCY_CACHELINE:
            readWord = latency_r;
         pci_cfg_pkg::OFF_IO_BASE:
            readWord = ioBase_r | pci_cfg_pkg::IO_SPACE_FLAG;
         pci_cfg_pkg::OFF_MEMORY_BASE:
            readWord = memBase_r;
         pci_cfg_pkg::OFF_CARD_INFO_POINTER:
            readWord = cardInfoPointer_r;
         pci_cfg_pkg::OFF_SUBSYSTEM_IDENT:
            readWord = subsystemIdent_r;
         pci_cfg_pkg::OFF_BOOT_ROM_BASE:
            readWord = bootRom_r;
         pci_cfg_pkg::OFF_CAPABILITY_POINTER:
            readWord = {24'h000000, pci_cfg_pkg::OFF_POWER_CAPABILITY};
         pci_cfg_pkg::OFF_INTERRUPT_CONFIG:
            readWord = {maxLat_r, minGnt_r, INT_PIN, intLine_r[7:0]};
         pci_cfg_pkg::OFF_DRIVER_SCRATCH:
            readWord = scratch_r & pci_cfg_pkg::MASK_SCRATCH;
         pci_cfg_pkg::OFF_CHIP_SIGNATURE:
            readWord = SIGNATURE_VALUE;
         pci_cfg_pkg::OFF_POWER_CAPABILITY:
            readWord = {POWER_CAPS, pci_cfg_pkg::CAP_NEXT_NONE,
               pci_cfg_pkg::CAPABILITY_IDENT_POWER};
         pci_cfg_pkg::OFF_POWER_CONTROL_STATUS:
            readWord = powerCtl_r;
         default:
            readWord = 32'h0000_0000;
      endcase
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfgRdData <= 32'h0000_0000;
         cfgRdValid <= 1'b0;
      end else begin
         cfgRdValid <= cfgRead;
         if (cfgRead) begin
            cfgRdData <= readWord;
         end
      end
   end

   // -------------------------------------------------------------
   // decoded control outputs
   // -------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ioSpaceEnable <= 1'b0;
         memSpaceEnable <= 1'b0;
         busMasterEnable <= 1'b0;
         latencyTimer <= 8'h00;
         cacheLineSize <= 8'h00;
         powerState <= 2'h0;
      end else begin
         ioSpaceEnable <= command_r[pci_cfg_pkg::BIT_IO_ENABLE];
         memSpaceEnable <= command_r[pci_cfg_pkg::BIT_MEM_ENABLE];
         busMasterEnable <= command_r[pci_cfg_pkg::BIT_MASTER_ENABLE];
         latencyTimer <= latency_r[15:8];
         cacheLineSize <= latency_r[7:0];
         powerState <= powerCtl_r[1:0];
      end
   end

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   sequence readAt(logic [7:0] off);
      cfgRead && (cfgAddr & 8'hFC) == off;
   endsequence

   sequence serrThenFlag;
      serrAssert ##1 systemErrorFlag_r;
   endsequence

   ident_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      readAt(pci_cfg_pkg::OFF_LOADED_IDENT) |=> cfgRdValid &&
      cfgRdData == {$past(loadedDeviceIdent_r), $past(loadedVendorIdent_r)})
      else $error("identifier read mismatch");

   eeprom_recall_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      recall_r == pci_cfg_pkg::RECALL_WAIT && eeLoadDone |=>
      loadedVendorIdent_r == $past(eeVendorIdent) &&
      subsystemIdent_r == $past(eeSubsystemIdent) && !eeLoadRequest)
      else $error("eeprom recall not captured");

   cis_readonly_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      cfgWrite && recall_r == pci_cfg_pkg::RECALL_DONE |=>
      $stable(cardInfoPointer_r))
      else $error("card info pointer changed by write");

   scratch_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      readAt(pci_cfg_pkg::OFF_DRIVER_SCRATCH) |=>
      cfgRdData[31:16] == 16'h0000 && cfgRdData[7:0] == 8'h00)
      else $error("driver word reserved bits set");

   signature_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      readAt(pci_cfg_pkg::OFF_CHIP_SIGNATURE) |=>
      cfgRdData == SIGNATURE_VALUE)
      else $error("signature word changed");

   parity_flag_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      dataParityErr || addrParityErr |=> parityErrorFlag_r)
      else $error("parity flag not set");

   serr_path_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      addrParityErr && command_r[pci_cfg_pkg::BIT_SYSTEM_ERROR_EN] |=>
      serrThenFlag)
      else $error("system error not signalled and flagged");

   master_abort_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      masterAbort |=> masterAbortFlag_r)
      else $error("master abort flag not set");

   target_abort_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      targetAbort |=> targetAbortFlag_r)
      else $error("target abort flag not set");

   status_fixed_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      readAt(pci_cfg_pkg::OFF_COMMAND_STATUS) |=>
      cfgRdData[26:25] == 2'h1 && cfgRdData[23] && cfgRdData[20] &&
      cfgRdData[27] == 1'b0)
      else $error("fixed status bits wrong");

   data_parity_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(dataParityFlag_r) |-> $past(busMasterActive) &&
      $past(perrDriven || perrObserved) &&
      $past(command_r[pci_cfg_pkg::BIT_PARITY_RESPONSE]))
      else $error("data parity flag set without cause");

   reset_value_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      $rose(reset_n) |-> commandStatus == pci_cfg_pkg::COMMAND_STATUS_RESET)
      else $error("command status reset value wrong");

   parity_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      dataParityErr && !command_r[pci_cfg_pkg::BIT_PARITY_RESPONSE] &&
      !addrParityErr |=> !perrAssert && !parityErrReport)
      else $error("parity response while disabled");

   reserved_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
      readAt(8'h18) or readAt(8'h38) or readAt(8'h44) |=>
      cfgRdData == 32'h0000_0000)
      else $error("reserved offset not zero");

endmodule

// file: dv/ee_recall_model.sv
/* EEPROM reader stand-in: answers the recall request once per reset.
   Assumes the register bank's recall handshake on ref_clk. */
`timescale 1ns/1ps
module ee_recall_model #(
   parameter logic [15:0] DEV = 16'h0000,
   parameter logic [15:0] VEN = 16'h0000,
   parameter logic [31:0] CARD = 32'h0000_0000,
   parameter logic [31:0] SUB = 32'h0000_0000,
   parameter logic [7:0] MAXLAT = 8'h00,
   parameter logic [7:0] MINGNT = 8'h00,
   parameter int DELAY = 20
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // recall handshake
   input wire logic eeLoadRequest,
   output logic eeLoadDone,
   // recalled values
   output logic [15:0] eeDeviceIdent,
   output logic [15:0] eeVendorIdent,
   output logic [31:0] eeCardInfo,
   output logic [31:0] eeSubsystemIdent,
   output logic [7:0] eeMaxLat,
   output logic [7:0] eeMinGnt
);
   int cnt;
   // one pulse, DELAY cycles into the request
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt <= 0;
         eeLoadDone <= 1'b0;
      end else begin
         if (eeLoadRequest && cnt < DELAY) cnt <= cnt + 1;
         eeLoadDone <= eeLoadRequest && cnt == DELAY - 1;
      end
   end
   // values valid only with the pulse, inverted otherwise
   assign eeDeviceIdent = eeLoadDone ? DEV : ~DEV;
   assign eeVendorIdent = eeLoadDone ? VEN : ~VEN;
   assign eeCardInfo = eeLoadDone ? CARD : ~CARD;
   assign eeSubsystemIdent = eeLoadDone ? SUB : ~SUB;
   assign eeMaxLat = eeLoadDone ? MAXLAT : ~MAXLAT;
   assign eeMinGnt = eeLoadDone ? MINGNT : ~MINGNT;
endmodule

// file: dv/test_pci_config_header_regs.sv
/* Self-checking bench for the configuration header bank.
   Assumes the config strobe protocol and the event pulse ports. */
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin miscompares++; \
   $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module test_pci_config_header_regs;
   localparam logic [31:0] SIG = 32'h5EED_0C3A; // arbitrary
   localparam logic [15:0] DEV = 16'h3A5C; // arbitrary
   localparam logic [15:0] VEN = 16'h7E21; // arbitrary
   localparam logic [31:0] SUB = 32'hB00C_5AB1; // arbitrary
   logic ref_clk, reset_n, cfgRead, cfgWrite, cfgRdValid, serrAssert;
   logic eeLoadRequest, eeLoadDone;
   logic perrAssert, parityErrReport;
   logic ioSpaceEnable, memSpaceEnable, busMasterEnable;
   logic [7:0] cfgAddr, eeMaxLat, eeMinGnt, latencyTimer, cacheLineSize;
   logic [1:0] powerState;
   logic [3:0] cfgByteEn;
   logic [31:0] cfgWrData, cfgRdData, eeCardInfo, eeSubsystemIdent;
   logic [15:0] eeDeviceIdent, eeVendorIdent;
   logic [6:0] ev;
   int miscompares, checked;
   pci_config_header_regs #(.SIGNATURE_VALUE(SIG)) pci_config_header_regs_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .cfgRead(cfgRead),
      .cfgWrite(cfgWrite), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
      .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
      .eeLoadRequest(eeLoadRequest), .eeLoadDone(eeLoadDone),
      .eeDeviceIdent(eeDeviceIdent), .eeVendorIdent(eeVendorIdent),
      .eeCardInfo(eeCardInfo), .eeSubsystemIdent(eeSubsystemIdent),
      .eeMaxLat(eeMaxLat), .eeMinGnt(eeMinGnt), .dataParityErr(ev[6]),
      .addrParityErr(ev[5]), .masterAbort(ev[4]), .targetAbort(ev[3]),
      .busMasterActive(ev[2]), .perrDriven(ev[1]), .perrObserved(ev[0]),
      .serrAssert(serrAssert), .perrAssert(perrAssert),
      .parityErrReport(parityErrReport), .ioSpaceEnable(ioSpaceEnable),
      .memSpaceEnable(memSpaceEnable), .busMasterEnable(busMasterEnable),
      .latencyTimer(latencyTimer), .cacheLineSize(cacheLineSize),
      .powerState(powerState));
   ee_recall_model #(.DEV(DEV), .VEN(VEN), .CARD(32'h0000_1234), .SUB(SUB),
      .MAXLAT(8'h18), .MINGNT(8'h05)) ee_recall_model_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .eeLoadRequest(eeLoadRequest),
      .eeLoadDone(eeLoadDone), .eeDeviceIdent(eeDeviceIdent),
      .eeVendorIdent(eeVendorIdent), .eeCardInfo(eeCardInfo),
      .eeSubsystemIdent(eeSubsystemIdent), .eeMaxLat(eeMaxLat),
      .eeMinGnt(eeMinGnt));
   // ------------------------------------------------------------
   // access tasks
   // ------------------------------------------------------------
   task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
      @(posedge ref_clk);
      cfgWrite <= 1'b1;
      cfgAddr <= a;
      cfgByteEn <= be;
      cfgWrData <= d;
      @(posedge ref_clk);
      cfgWrite <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge ref_clk);
      cfgRead <= 1'b1;
      cfgAddr <= a;
      @(posedge ref_clk);
      cfgRead <= 1'b0;
      #1;
      `CHK(cfgRdValid, 1'b1)
      `CHK(cfgRdData, e)
   endtask
   task evt(input logic [6:0] v, input logic serr, input logic [1:0] perr);
      @(posedge ref_clk);
      ev <= v;
      @(posedge ref_clk);
      ev <= 7'h00;
      #1;
      `CHK(serrAssert, serr)
      `CHK(perrAssert, perr[1])
      `CHK(parityErrReport, perr[0])
   endtask
   task wrap_up();
      if (miscompares == 0 && checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   initial begin
      repeat (5000) @(posedge ref_clk);
      miscompares++;
      wrap_up();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      cfgRead = 1'b0;
      cfgWrite = 1'b0;
      ev = 7'h00;
      cfgAddr = 8'h00;
      cfgByteEn = 4'h0;
      cfgWrData = 32'h0000_0000;
      repeat (12) @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h04, 32'h0290_0000);
      rd(8'h00, 32'h0000_0000);
      for (int n = 0; n < 60 && eeLoadRequest !== 1'b0; n++)
         @(posedge ref_clk);
      `CHK(eeLoadRequest, 1'b0)
      rd(8'h00, {DEV, VEN});
      rd(8'h2C, SUB);
      rd(8'h3C, 32'h1805_0100);
      wr(8'h28, 4'hF, 32'hFFFF_FFFF);
      rd(8'h28, 32'h0000_1234);
      wr(8'h40, 4'hF, 32'hFFFF_FFFF);
      rd(8'h40, 32'h0000_FF00);
      wr(8'h80, 4'hF, 32'h0000_0000);
      rd(8'h80, SIG);
      wr(8'h18, 4'hF, 32'hFFFF_FFFF);
      rd(8'h18, 32'h0000_0000);
      wr(8'h04, 4'h3, 32'h0000_0140);
      evt(7'h20, 1'b1, 2'h1);
      rd(8'h04, 32'hC290_0140);
      wr(8'h04, 4'h8, 32'hFF00_0000);
      evt(7'h10, 1'b0, 2'h0);
      evt(7'h08, 1'b0, 2'h0);
      rd(8'h04, 32'h3290_0140);
      wr(8'h04, 4'h8, 32'hFF00_0000);
      evt(7'h46, 1'b0, 2'h3);
      rd(8'h04, 32'h8390_0140);
      wr(8'h04, 4'h8, 32'hFF00_0000);
      wr(8'h04, 4'h3, 32'h0000_0100);
      evt(7'h45, 1'b0, 2'h0);
      rd(8'h04, 32'h8290_0100);
      wr(8'h04, 4'h1, 32'h0000_0007);
      wr(8'h0C, 4'hF, 32'hFFFF_FFFF);
      wr(8'hC4, 4'hF, 32'hFFFF_FFFF);
      rd(8'h0C, 32'h0000_FFFF);
      rd(8'hC4, 32'h0000_0003);
      `CHK(ioSpaceEnable, 1'b1)
      `CHK(memSpaceEnable, 1'b1)
      `CHK(busMasterEnable, 1'b1)
      `CHK(latencyTimer, 8'hFF)
      `CHK(cacheLineSize, 8'hFF)
      `CHK(powerState, 2'h3)
      @(posedge ref_clk);
      reset_n <= 1'b0;
      @(posedge ref_clk);
      reset_n <= 1'b1;
      rd(8'h04, 32'h0290_0000);
      rd(8'h00, 32'h0000_0000);
      `CHK(busMasterEnable, 1'b0)
      wrap_up();
   end
endmodule
